// File: include/clk_synth_pkg.sv
// Purpose: shared constants, types and decode helpers for the clock synthesizer registers
// Assumes: 8-bit indexed register space behind an index port and a data port
// Notes:   every offset, field position and parameter register reset value is named here once
package clk_synth_pkg;

  // ----------------------------------------------------------------
  // io ports and register indexes
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_INDEX_PORT  = 16'h03D6;
  localparam logic [15:0] IO_DATA_PORT   = 16'h03D7;
  localparam logic [7:0]  IDX_V0_SEL     = 8'hC3;
  localparam logic [7:0]  IDX_V1_MULT    = 8'hC4;
  localparam logic [7:0]  IDX_V1_DIV     = 8'hC5;
  localparam logic [7:0]  IDX_V1_UPPER   = 8'hC6;
  localparam logic [7:0]  IDX_V1_SEL     = 8'hC7;
  localparam logic [7:0]  IDX_V2_MULT    = 8'hC8;
  localparam logic [7:0]  IDX_V2_DIV     = 8'hC9;
  localparam logic [7:0]  IDX_V2_UPPER   = 8'hCA;
  localparam logic [7:0]  IDX_V2_SEL     = 8'hCB;
  localparam logic [7:0]  IDX_M_MULT     = 8'hCC;
  localparam logic [7:0]  IDX_M_DIV      = 8'hCD;
  localparam logic [7:0]  IDX_M_SEL      = 8'hCE;
  localparam logic [7:0]  IDX_CFG_STATUS = 8'hCF;

  // ----------------------------------------------------------------
  // field layout and writable masks
  // ----------------------------------------------------------------
  localparam int          SEL_POST_LSB   = 4;
  localparam int          SEL_LOOP_BIT   = 2;
  localparam int          SEL_REFDIV5    = 1;
  localparam int          SEL_REFDIV1    = 0;
  localparam int          M_SEL_PROG_BIT = 7;
  localparam int          UP_DIV_LSB     = 4;
  localparam int          UP_MULT_LSB    = 0;
  localparam int          CFG_PWRSEQ_BIT = 3;
  localparam int          CFG_VSRC_BIT   = 2;
  localparam int          CFG_MSRC_BIT   = 1;
  localparam logic [7:0]  V_SEL_MASK     = 8'h77;
  localparam logic [7:0]  V_UPPER_MASK   = 8'h33;
  localparam logic [7:0]  M_PARAM_MASK   = 8'h7F;
  localparam logic [7:0]  M_SEL_MASK     = 8'hF1;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [9:0]  V0_MULT_RESET  = 10'h000;
  localparam logic [9:0]  V0_DIV_RESET   = 10'h000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          PWRSEQ_REF_DIV = 384;
  localparam logic [8:0]  PWRSEQ_LAST    = 9'(PWRSEQ_REF_DIV - 1);
  localparam int          MCLK_DEFAULT_KHZ = 25175;

  // ----------------------------------------------------------------
  // synthesizer setting handed to the analog side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] mult;       // feedback multiplier
    logic [9:0] div;        // input divisor
    logic [2:0] post_code;  // raw post divider code
    logic [5:0] post_ratio; // 1..32, 0 on reserved code
    logic [4:0] loop_mul;   // 4 or 16 times multiplier
    logic [2:0] ref_pre;    // 1 or 5
    logic [2:0] ref_div;    // 4 or 1
  } synth_cfg_t;

  function automatic synth_cfg_t make_cfg(input logic [9:0] mult,
                                          input logic [9:0] div,
                                          input logic [7:0] sel);
    synth_cfg_t c;
    c.mult       = mult;
    c.div        = div;
    c.post_code  = sel[SEL_POST_LSB +: 3];
    c.post_ratio = (c.post_code > 3'h5) ? 6'h00 : 6'(6'h01 << c.post_code);
    c.loop_mul   = sel[SEL_LOOP_BIT] ? 5'h10 : 5'h04;
    c.ref_pre    = sel[SEL_REFDIV5] ? 3'h5 : 3'h1;
    c.ref_div    = sel[SEL_REFDIV1] ? 3'h1 : 3'h4;
    return c;
  endfunction

endpackage

// File: rtl/vclk_stage.sv
// Purpose: one video clock generator: staged parameter registers and active copy
// Assumes: write strobes are one-cycle pulses already decoded from the data port
// Notes:   the active copy changes only on a divisor-select write
`timescale 1ns/1ps
`default_nettype none
module vclk_stage #(
  parameter logic [9:0] MULT_RESET = 10'h000, // reset of multiplier shadow
  parameter logic [9:0] DIV_RESET  = 10'h000  // reset of divisor shadow
) (
  input  wire logic                      core_clk,  // system clock
  input  wire logic                      resetn,    // async reset, low
  input  wire logic                      wr_mult,   // write multiplier low
  input  wire logic                      wr_div,    // write divisor low
  input  wire logic                      wr_upper,  // write upper bits
  input  wire logic                      wr_sel,    // write divisor select
  input  wire logic [7:0]                wdata,     // write data
  output logic      [9:0]                sh_mult,   // shadow multiplier
  output logic      [9:0]                sh_div,    // shadow divisor
  output logic      [7:0]                sh_sel,    // shadow divisor select
  output clk_synth_pkg::synth_cfg_t      active,    // setting to synthesizer
  output logic                           load       // pulse on transfer
);

  // ----------------------------------------------------------------
  // shadow copy
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sh_mult <= MULT_RESET;
      sh_div  <= DIV_RESET;
    end else begin
      if (wr_mult)  sh_mult[7:0] <= wdata; // [R07] [R16]
      if (wr_div)   sh_div[7:0]  <= wdata; // [R07] [R16]
      if (wr_upper) begin
        sh_mult[9:8] <= wdata[clk_synth_pkg::UP_MULT_LSB +: 2]; // [R07]
        sh_div[9:8]  <= wdata[clk_synth_pkg::UP_DIV_LSB +: 2];  // [R07]
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sh_sel <= clk_synth_pkg::REG_RESET;
    else if (wr_sel) sh_sel <= wdata & clk_synth_pkg::V_SEL_MASK;
  end

  // ----------------------------------------------------------------
  // active copy, loaded all at once
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active <= clk_synth_pkg::make_cfg(MULT_RESET, DIV_RESET,
                                        clk_synth_pkg::REG_RESET);
      load   <= 1'b0;
    end else begin
      load <= wr_sel; // [R02]
      if (wr_sel)
        active <= clk_synth_pkg::make_cfg(sh_mult, sh_div,
                    wdata & clk_synth_pkg::V_SEL_MASK); // [R01] [R03] [R04] [R05] [R06]
    end
  end

endmodule
`default_nettype wire

// File: rtl/pwr_seq_tick.sv
// Purpose: timing tick for panel power sequencing and standby refresh
// Assumes: ref_tick and tick_32k are one-cycle enables in the core clock domain
// Notes:   reference path counts 384 reference ticks per output tick
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_tick (
  input  wire logic core_clk,  // system clock
  input  wire logic resetn,    // async reset, low
  input  wire logic use_32k,   // select 32 kHz source
  input  wire logic ref_tick,  // one pulse per reference cycle
  input  wire logic tick_32k,  // one pulse per 32 kHz cycle
  output logic      tick       // one-cycle sequencing tick
);

  logic [8:0] ref_cnt;
  logic       ref_wrap;

  assign ref_wrap = ref_tick && (ref_cnt == clk_synth_pkg::PWRSEQ_LAST);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) ref_cnt <= 9'h000;
    else if (ref_tick) ref_cnt <= ref_wrap ? 9'h000 : 9'(ref_cnt + 9'h001);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) tick <= 1'b0;
    else tick <= use_32k ? tick_32k : ref_wrap; // [R10]
  end

endmodule
`default_nettype wire

// File: rtl/clk_synth_regs.sv
// Purpose: clock synthesizer programming registers behind the indexed io port
// Assumes: io strobes are single-cycle and synchronous to core_clk
// Notes:   read data is registered and valid the cycle after io_rd
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: video clock parameters are staged, then moved together on divisor-select write.
// R02: new video frequency applies only after its divisor-select write.
// R03: post divider codes 000..101 divide by 1..32; 110 and 111 reserved.
// R04: loop divide bit picks 4 or 16 times the multiplier.
// R05: reference clock bit passes reference straight or divides it by five.
// R06: reference divisor bit picks divide by 4 or by 1, all clocks.
// R07: ten-bit multiplier and divisor; upper bits from the shared upper register.
// R08: software clears memory clock select before changing memory parameters.
// R09: memory select bit clear gives fixed default clock; set uses programmed values.
// R10: configuration bit 3 picks reference/384 or 32 kHz sequencing source.
// R11: clock configuration register is read-only; writes change nothing.
// R12: all parameter registers are read and written through the data port.
// R13: software loads the index port, then uses the data port.
// R14: video clock source bit shows the latched strap, 1 for internal.
// R15: memory clock source bit shows the latched strap, 1 for internal.
// R16: staged shadow values remain readable before the transfer.
module clk_synth_regs (
  input  wire logic                       core_clk,          // system clock
  input  wire logic                       resetn,            // async reset, low
  input  wire logic [15:0]                io_addr,           // io port address
  input  wire logic                       io_wr,             // io write strobe
  input  wire logic                       io_rd,             // io read strobe
  input  wire logic [7:0]                 io_wdata,          // io write data
  output logic      [7:0]                 io_rdata,          // io read data
  input  wire logic                       ref_tick,          // reference cycle pulse
  input  wire logic                       tick_32k,          // 32 kHz cycle pulse
  input  wire logic                       vclk_src_strap,    // video source strap
  input  wire logic                       mclk_src_strap,    // memory source strap
  input  wire logic                       pwrseq_src_strap,  // sequencing source strap
  output clk_synth_pkg::synth_cfg_t       vclk0_cfg,         // video clock 0 setting
  output clk_synth_pkg::synth_cfg_t       vclk1_cfg,         // video clock 1 setting
  output clk_synth_pkg::synth_cfg_t       vclk2_cfg,         // video clock 2 setting
  output logic      [2:0]                 vclk_load,         // per clock transfer pulse
  output clk_synth_pkg::synth_cfg_t       mclk_cfg,          // memory clock setting
  output logic                            mclk_use_default,  // memory clock fixed default
  output logic                            vclk_internal,     // video oscillator enabled
  output logic                            mclk_internal,     // memory oscillator enabled
  output logic                            pwrseq_tick        // sequencing timing tick
);

  // ----------------------------------------------------------------
  // index port and data port decode
  // ----------------------------------------------------------------
  logic [7:0] index;
  logic       idx_hit;
  logic       data_hit;
  logic       data_wr;
  logic       data_rd;

  assign idx_hit  = (io_addr == clk_synth_pkg::IO_INDEX_PORT);
  assign data_hit = (io_addr == clk_synth_pkg::IO_DATA_PORT);
  assign data_wr  = io_wr && data_hit; // [R12]
  assign data_rd  = io_rd && data_hit; // [R12]

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) index <= clk_synth_pkg::REG_RESET;
    else if (io_wr && idx_hit) index <= io_wdata; // [R13]
  end

  // ----------------------------------------------------------------
  // per-register write strobes
  // ----------------------------------------------------------------
  logic [2:0] wr_mult;
  logic [2:0] wr_div;
  logic [2:0] wr_upper;
  logic [2:0] wr_sel;
  logic       wr_m_mult;
  logic       wr_m_div;
  logic       wr_m_sel;

  assign wr_mult[0]  = 1'b0;
  assign wr_div[0]   = 1'b0;
  assign wr_upper[0] = 1'b0;
  assign wr_sel[0]   = data_wr && (index == clk_synth_pkg::IDX_V0_SEL);
  assign wr_mult[1]  = data_wr && (index == clk_synth_pkg::IDX_V1_MULT);
  assign wr_div[1]   = data_wr && (index == clk_synth_pkg::IDX_V1_DIV);
  assign wr_upper[1] = data_wr && (index == clk_synth_pkg::IDX_V1_UPPER);
  assign wr_sel[1]   = data_wr && (index == clk_synth_pkg::IDX_V1_SEL);
  assign wr_mult[2]  = data_wr && (index == clk_synth_pkg::IDX_V2_MULT);
  assign wr_div[2]   = data_wr && (index == clk_synth_pkg::IDX_V2_DIV);
  assign wr_upper[2] = data_wr && (index == clk_synth_pkg::IDX_V2_UPPER);
  assign wr_sel[2]   = data_wr && (index == clk_synth_pkg::IDX_V2_SEL);
  assign wr_m_mult   = data_wr && (index == clk_synth_pkg::IDX_M_MULT);
  assign wr_m_div    = data_wr && (index == clk_synth_pkg::IDX_M_DIV);
  assign wr_m_sel    = data_wr && (index == clk_synth_pkg::IDX_M_SEL);

  // ----------------------------------------------------------------
  // video clock generators
  // ----------------------------------------------------------------
  logic [9:0]                 sh_mult [3];
  logic [9:0]                 sh_div  [3];
  logic [7:0]                 sh_sel  [3];
  clk_synth_pkg::synth_cfg_t  v_active [3];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_vclk
      vclk_stage #(
        .MULT_RESET (clk_synth_pkg::V0_MULT_RESET),
        .DIV_RESET  (clk_synth_pkg::V0_DIV_RESET)
      ) u_stage (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_mult  (wr_mult[g]),
        .wr_div   (wr_div[g]),
        .wr_upper (wr_upper[g]),
        .wr_sel   (wr_sel[g]),
        .wdata    (io_wdata),
        .sh_mult  (sh_mult[g]),
        .sh_div   (sh_div[g]),
        .sh_sel   (sh_sel[g]),
        .active   (v_active[g]),
        .load     (vclk_load[g])
      );
    end
  endgenerate

  assign vclk0_cfg = v_active[0];
  assign vclk1_cfg = v_active[1];
  assign vclk2_cfg = v_active[2];

  // ----------------------------------------------------------------
  // memory clock registers, applied directly
  // ----------------------------------------------------------------
  logic [7:0] m_mult;
  logic [7:0] m_div;
  logic [7:0] m_sel;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      m_mult <= clk_synth_pkg::REG_RESET;
      m_div  <= clk_synth_pkg::REG_RESET;
    end else begin
      if (wr_m_mult) m_mult <= io_wdata & clk_synth_pkg::M_PARAM_MASK; // [R12]
      if (wr_m_div)  m_div  <= io_wdata & clk_synth_pkg::M_PARAM_MASK; // [R12]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) m_sel <= clk_synth_pkg::REG_RESET;
    else if (wr_m_sel) m_sel <= io_wdata & clk_synth_pkg::M_SEL_MASK;
  end

  // memory path has no loop or prescale bits; only bit 0 and post code apply
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mclk_cfg         <= clk_synth_pkg::make_cfg(10'h000, 10'h000,
                                                  clk_synth_pkg::REG_RESET);
      mclk_use_default <= 1'b1;
    end else begin
      mclk_cfg         <= clk_synth_pkg::make_cfg({2'b00, m_mult}, {2'b00, m_div},
                            m_sel & clk_synth_pkg::M_SEL_MASK); // [R03] [R06]
      mclk_use_default <= !m_sel[clk_synth_pkg::M_SEL_PROG_BIT]; // [R09] [R08]
    end
  end

  // ----------------------------------------------------------------
  // configuration straps, caught once after reset release
  // ----------------------------------------------------------------
  logic strap_done;
  logic strap_vsrc;
  logic strap_msrc;
  logic strap_pwr;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_done <= 1'b0;
      strap_vsrc <= 1'b0;
      strap_msrc <= 1'b0;
      strap_pwr  <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_vsrc <= vclk_src_strap; // [R14]
      strap_msrc <= mclk_src_strap; // [R15]
      strap_pwr  <= pwrseq_src_strap;
    end
  end

  assign vclk_internal = strap_vsrc; // [R14]
  assign mclk_internal = strap_msrc; // [R15]

  // status assembled only from hardware state; no write path exists
  logic [7:0] cfg_status;

  always_comb begin
    cfg_status = 8'h00;
    cfg_status[clk_synth_pkg::CFG_PWRSEQ_BIT] = strap_pwr;  // [R11]
    cfg_status[clk_synth_pkg::CFG_VSRC_BIT]   = strap_vsrc; // [R14]
    cfg_status[clk_synth_pkg::CFG_MSRC_BIT]   = strap_msrc; // [R15]
  end

  // ----------------------------------------------------------------
  // power sequencing timing source
  // ----------------------------------------------------------------
  pwr_seq_tick u_pwr_seq (
    .core_clk (core_clk),
    .resetn   (resetn),
    .use_32k  (strap_pwr), // [R10]
    .ref_tick (ref_tick),
    .tick_32k (tick_32k),
    .tick     (pwrseq_tick)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] data_mux;

  function automatic logic [7:0] upper_byte(input logic [9:0] mult,
                                            input logic [9:0] div);
    upper_byte = {2'b00, div[9:8], 2'b00, mult[9:8]};
  endfunction

  always_comb begin
    case (index)
      clk_synth_pkg::IDX_V0_SEL:     data_mux = sh_sel[0];
      clk_synth_pkg::IDX_V1_MULT:    data_mux = sh_mult[1][7:0]; // [R16]
      clk_synth_pkg::IDX_V1_DIV:     data_mux = sh_div[1][7:0];  // [R16]
      clk_synth_pkg::IDX_V1_UPPER:   data_mux = upper_byte(sh_mult[1], sh_div[1]); // [R07]
      clk_synth_pkg::IDX_V1_SEL:     data_mux = sh_sel[1];
      clk_synth_pkg::IDX_V2_MULT:    data_mux = sh_mult[2][7:0]; // [R16]
      clk_synth_pkg::IDX_V2_DIV:     data_mux = sh_div[2][7:0];  // [R16]
      clk_synth_pkg::IDX_V2_UPPER:   data_mux = upper_byte(sh_mult[2], sh_div[2]); // [R07]
      clk_synth_pkg::IDX_V2_SEL:     data_mux = sh_sel[2];
      clk_synth_pkg::IDX_M_MULT:     data_mux = m_mult;
      clk_synth_pkg::IDX_M_DIV:      data_mux = m_div;
      clk_synth_pkg::IDX_M_SEL:      data_mux = m_sel;
      clk_synth_pkg::IDX_CFG_STATUS: data_mux = cfg_status; // [R11]
      default:                       data_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_rdata = io_rdata;
    if (io_rd && idx_hit) next_rdata = index;
    else if (data_rd) next_rdata = data_mux; // [R12]
    else if (io_rd) next_rdata = 8'h00;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) io_rdata <= 8'h00;
    else io_rdata <= next_rdata;
  end

endmodule
`default_nettype wire

// File: dv/clk_synth_regs_checker.sv
// Purpose: port-level checks of the clock synthesizer register block
// Assumes: index port written before each data port access
// Notes:   the index is mirrored here to decode data port cycles
`timescale 1ns/1ps
`default_nettype none
module clk_synth_regs_checker (
  input wire logic                       core_clk,          // system clock
  input wire logic                       resetn,            // async reset, low
  input wire logic [15:0]                io_addr,           // io address
  input wire logic                       io_wr,             // io write strobe
  input wire logic                       io_rd,             // io read strobe
  input wire logic [7:0]                 io_wdata,          // io write data
  input wire logic [7:0]                 io_rdata,          // io read data
  input wire clk_synth_pkg::synth_cfg_t  vclk0_cfg,         // video clock 0 setting
  input wire clk_synth_pkg::synth_cfg_t  vclk1_cfg,         // video clock 1 setting
  input wire clk_synth_pkg::synth_cfg_t  vclk2_cfg,         // video clock 2 setting
  input wire logic [2:0]                 vclk_load,         // transfer pulses
  input wire logic                       mclk_use_default,  // memory default clock
  input wire logic                       vclk_internal,     // video oscillator on
  input wire logic                       mclk_internal      // memory oscillator on
);
  logic [7:0] idx;
  logic       dwr;
  logic       drd;
  assign dwr = io_wr && (io_addr == 16'h03D7);
  assign drd = io_rd && (io_addr == 16'h03D7);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idx <= 8'h00;
    end else if (io_wr && (io_addr == 16'h03D6)) begin
      idx <= io_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_sel_load;
    dwr && (idx == 8'hC7) |=> (vclk_load == 3'b010) ##1 (vclk_load == 3'b000);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("vclk1 pulse wrong");
  property p_hold;
    $changed(vclk1_cfg) |-> vclk_load[1];
  endproperty
  a_hold: assert property (p_hold) else $error("vclk1 moved without select");
  property p_post;
    vclk2_cfg.post_ratio == ((vclk2_cfg.post_code > 3'h5) ? 6'h00 : 6'h01 << vclk2_cfg.post_code);
  endproperty
  a_post: assert property (p_post) else $error("post ratio wrong");
  property p_loop;
    dwr && (idx == 8'hC7) |=> vclk1_cfg.loop_mul == ($past(io_wdata[2]) ? 5'h10 : 5'h04);
  endproperty
  a_loop: assert property (p_loop) else $error("loop divide wrong");
  property p_pre;
    dwr && (idx == 8'hCB) |=> vclk2_cfg.ref_pre == ($past(io_wdata[1]) ? 3'h5 : 3'h1);
  endproperty
  a_pre: assert property (p_pre) else $error("reference divide wrong");
  property p_rdiv;
    dwr && (idx == 8'hC3) |=> vclk0_cfg.ref_div == ($past(io_wdata[0]) ? 3'h1 : 3'h4);
  endproperty
  a_rdiv: assert property (p_rdiv) else $error("reference divisor wrong");
  property p_upper;
    drd && (idx == 8'hC6) |=> (io_rdata[7:6] == 2'h0) && (io_rdata[3:2] == 2'h0);
  endproperty
  a_upper: assert property (p_upper) else $error("upper reserved bits set");
  property p_mdef;
    dwr && (idx == 8'hCE) |-> ##2 mclk_use_default == !$past(io_wdata[7], 2);
  endproperty
  a_mdef: assert property (p_mdef) else $error("memory default wrong");
  property p_cfg;
    drd && (idx == 8'hCF) |=> io_rdata[2:1] == {vclk_internal, mclk_internal};
  endproperty
  a_cfg: assert property (p_cfg) else $error("source bits wrong");
  property p_rhold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
endmodule
bind clk_synth_regs clk_synth_regs_checker i_clk_synth_regs_checker (.core_clk, .resetn,
  .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .vclk0_cfg, .vclk1_cfg, .vclk2_cfg,
  .vclk_load, .mclk_use_default, .vclk_internal, .mclk_internal);
`default_nettype wire

// File: dv/tb_clk_synth_regs.sv
// Purpose: directed register-level bench for the clock synthesizer block
// Assumes: inputs change at the falling clock edge
// Notes:   ref_tick every 2 cycles, tick_32k every 50 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_clk_synth_regs;
  logic                       core_clk, resetn, io_wr, io_rd, ref_tick, tick_32k;
  logic                       vclk_src_strap, mclk_src_strap, pwrseq_src_strap;
  logic                       mclk_use_default, vclk_internal, mclk_internal, pwrseq_tick;
  logic [15:0]                io_addr;
  logic [7:0]                 io_wdata, io_rdata, sel;
  logic [2:0]                 vclk_load;
  clk_synth_pkg::synth_cfg_t  vclk0_cfg, vclk1_cfg, vclk2_cfg, mclk_cfg;
  int                         err_total, total_checks, gap, cyc;
  clk_synth_regs i_clk_synth_regs (.core_clk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .ref_tick, .tick_32k, .vclk_src_strap, .mclk_src_strap, .pwrseq_src_strap,
    .vclk0_cfg, .vclk1_cfg, .vclk2_cfg, .vclk_load, .mclk_cfg, .mclk_use_default,
    .vclk_internal, .mclk_internal, .pwrseq_tick);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    cyc <= cyc + 1;
    ref_tick <= (cyc % 2 == 0);
    tick_32k <= (cyc % 50 == 0);
  end
  // expected synthesizer setting from the field layout
  function automatic clk_synth_pkg::synth_cfg_t vcfg(input logic [9:0] m, input logic [9:0] d,
                                                     input logic [7:0] s);
    vcfg.mult = m;
    vcfg.div = d;
    vcfg.post_code = s[6:4];
    vcfg.post_ratio = (s[6:4] > 3'h5) ? 6'h00 : 6'(6'h01 << s[6:4]);
    vcfg.loop_mul = s[2] ? 5'h10 : 5'h04;
    vcfg.ref_pre = s[1] ? 3'h5 : 3'h1;
    vcfg.ref_div = s[0] ? 3'h1 : 3'h4;
  endfunction
  task automatic io_cyc(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    io_wr = wr;
    io_rd = !wr;
    io_addr = addr;
    io_wdata = data;
    @(posedge core_clk);
    @(negedge core_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] data);
    io_cyc(1'b1, 16'h03D6, idx);
    io_cyc(1'b1, 16'h03D7, data);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    io_cyc(1'b1, 16'h03D6, idx);
    io_cyc(1'b0, 16'h03D7, 8'h00);
    `CHK(io_rdata, exp)
  endtask
  task automatic tick_gap(output int n);
    int w;
    w = 0;
    n = 0;
    do begin @(negedge core_clk); w++; end while (pwrseq_tick !== 1'b1 && w < 2000);
    do begin @(negedge core_clk); n++; end while (pwrseq_tick !== 1'b1 && n < 2000);
  endtask
  task automatic do_reset(input logic s);
    @(negedge core_clk);
    resetn = 1'b0;
    vclk_src_strap = s;
    mclk_src_strap = s;
    pwrseq_src_strap = s;
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 10);
    err_total++;
    end_sim();
  end
  initial begin
    {resetn, io_wr, io_rd, io_addr, io_wdata} = '0;
    {vclk_src_strap, mclk_src_strap, pwrseq_src_strap} = 3'b000;
    do_reset(1'b0);
    for (int i = 8'hC3; i <= 8'hCF; i++) rchk(8'(i), 8'h00);
    // staged video clock 1 programming
    wreg(8'hC4, 8'hA5);
    wreg(8'hC5, 8'h3C);
    wreg(8'hC6, 8'hFF);
    `CHK(vclk1_cfg, vcfg(10'h000, 10'h000, 8'h00))
    rchk(8'hC4, 8'hA5);
    rchk(8'hC6, 8'h33);
    wreg(8'hC7, 8'hFF);
    `CHK(vclk_load, 3'b010)
    `CHK(vclk1_cfg, vcfg(10'h3A5, 10'h33C, 8'h77))
    rchk(8'hC7, 8'h77);
    for (int c = 0; c < 8; c++) begin
      sel = {1'b0, 3'(c), 1'b0, 3'(c)};
      wreg(8'hCB, sel);
      `CHK(vclk2_cfg, vcfg(10'h000, 10'h000, sel))
      wreg(8'hC3, sel);
      `CHK(vclk0_cfg, vcfg(10'h000, 10'h000, sel))
    end
    // memory clock, default selected while changing parameters
    wreg(8'hCE, 8'h00);
    wreg(8'hCC, 8'hFF);
    wreg(8'hCD, 8'h81);
    wreg(8'hCE, 8'hFF);
    @(negedge core_clk);
    `CHK(mclk_use_default, 1'b0)
    `CHK(mclk_cfg, vcfg(10'h07F, 10'h001, 8'hF1))
    rchk(8'hCE, 8'hF1);
    wreg(8'hCE, 8'h01);
    @(negedge core_clk);
    `CHK(mclk_use_default, 1'b1)
    wreg(8'hCF, 8'hFF);
    rchk(8'hCF, 8'h00);
    rchk(8'h10, 8'h00);
    io_cyc(1'b0, 16'h03D6, 8'h00);
    `CHK(io_rdata, 8'h10)
    io_cyc(1'b0, 16'h0300, 8'h00);
    `CHK(io_rdata, 8'h00)
    tick_gap(gap);
    `CHK(gap, 768)
    do_reset(1'b1);
    rchk(8'hCF, 8'h0E);
    `CHK(vclk_internal, 1'b1)
    `CHK(mclk_internal, 1'b1)
    tick_gap(gap);
    `CHK(gap, 50)
    end_sim();
  end
endmodule
`default_nettype wire
